// ### logic/stlc_pkg.sv
package stlc_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int PC_W = 10;
    localparam int NUM_CORES = 6;
    localparam int WD_W = 5;
    localparam int RAM_LOCKS = 3;
    localparam int RAM_TAIL_WORDS = 16;

    localparam logic [ADDR_W-1:0] OFS_SERIAL_PORT_SETUP = 10'h1a9;
    localparam logic [ADDR_W-1:0] OFS_TRACE_SYNC_POINT = 10'h1aa;
    localparam logic [ADDR_W-1:0] OFS_TRACE_END_POINT = 10'h1ab;
    localparam logic [ADDR_W-1:0] OFS_TRACE_CONTROL = 10'h1ac;
    localparam logic [ADDR_W-1:0] OFS_WRITE_PROTECT_CONTROL = 10'h1ad;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK_KEY = 10'h1af;

    localparam int SP_SLEW_BIT = 7;
    localparam int SP_MODE_BIT = 6;
    localparam int SP_IRQ_BIT = 5;
    localparam int SP_WD_LSB = 0;
    localparam int TC_EN_BIT = 15;
    localparam int TC_SEL_LSB = 8;
    localparam int TC_LEN_LSB = 0;
    localparam int WP_DEV_BIT = 0;
    localparam int WP_RAM_LSB = 1;

    localparam logic [DATA_W-1:0] RST_SERIAL_PORT_SETUP = 16'h000a;
    localparam logic [DATA_W-1:0] RST_TRACE_SYNC_POINT = 16'h0000;
    localparam logic [DATA_W-1:0] RST_TRACE_END_POINT = 16'h0000;
    localparam logic [DATA_W-1:0] RST_TRACE_CONTROL = 16'h0000;
    localparam logic [DATA_W-1:0] RST_WRITE_PROTECT_CONTROL = 16'h0000;
    localparam logic [DATA_W-1:0] UNLOCK_KEY = 16'h1337;

    localparam logic [7:0] POST_FOREVER = 8'hff;
    localparam int GAP_UNIT_CYCLES = 32768;
    localparam int SYNC_W = 8;

    typedef enum logic [1:0] {
        TR_IDLE,
        TR_SYNC,
        TR_TRACE,
        TR_POST
    } stlc_phase_t;
endpackage

// ### logic/stlc_gap_watchdog.sv
`timescale 1ns/100ps
module stlc_gap_watchdog #(
    parameter int GAP_UNIT = stlc_pkg::GAP_UNIT_CYCLES,
    parameter int CNT_W = 21
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_armed,
    input wire logic i_cs_idle,
    input wire logic [stlc_pkg::WD_W-1:0] i_setting,
    // Event
    output logic o_timeout
);
    import stlc_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic fired;
        logic pulse;
    } stlc_wd_state_t;

    stlc_wd_state_t st;
    stlc_wd_state_t next_st;
    logic [CNT_W-1:0] limit;

    // Limit is (setting + 1) units of clock cycles
    assign limit = CNT_W'((32'(i_setting) + 32'd1) * 32'(GAP_UNIT));

    always_comb begin
        next_st = st;
        next_st.pulse = 1'b0;
        if (!i_armed || !i_cs_idle) begin
            next_st.cnt = '0;
            next_st.fired = 1'b0;
        end else if (!st.fired) begin
            if (st.cnt + CNT_W'(1) >= limit) begin
                next_st.pulse = 1'b1;
                next_st.fired = 1'b1;
            end else begin
                next_st.cnt = st.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_timeout = st.pulse;
endmodule

// ### logic/stlc_config_bank.sv
`timescale 1ns/100ps
module stlc_config_bank #(
    parameter int GAP_UNIT = stlc_pkg::GAP_UNIT_CYCLES,
    parameter logic [stlc_pkg::SYNC_W-1:0] SYNC_CODE = 8'ha5
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register access from the serial frame logic
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [stlc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [stlc_pkg::DATA_W-1:0] i_wdata,
    output logic [stlc_pkg::DATA_W-1:0] o_rdata,
    output logic o_rd_valid,
    // Serial port status
    input wire logic i_bad_frame,
    input wire logic i_burst_active,
    input wire logic i_cs_n_pin,
    output logic o_miso_fast_slew,
    output logic o_burst_mode_b,
    output logic o_gap_timeout,
    output logic o_irq_req,
    // Core program counters, ordered by select code
    input wire logic [stlc_pkg::NUM_CORES-1:0][stlc_pkg::PC_W-1:0] i_core_program_counter,
    // Trace output
    output logic o_dbg,
    output logic o_trace_valid,
    output logic [stlc_pkg::PC_W-1:0] o_trace_pc,
    // Lock state
    output logic o_dev_lock,
    output logic [stlc_pkg::RAM_LOCKS-1:0] o_ram_tail_lock
);
    import stlc_pkg::*;

    typedef struct packed {
        logic [7:0] ser;
        logic [PC_W-1:0] sync_pt;
        logic [PC_W-1:0] end_pt;
        logic en;
        logic [2:0] sel;
        logic [7:0] post_len;
        logic dev_lock;
        logic [RAM_LOCKS-1:0] ram_lock;
        stlc_phase_t phase;
        logic [7:0] post_cnt;
        logic [SYNC_W-1:0] sync_sh;
        logic [3:0] sync_left;
        logic dbg;
        logic tr_valid;
        logic [PC_W-1:0] tr_pc;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic irq;
        logic [1:0] cs_sync;
    } stlc_state_t;

    stlc_state_t st;
    stlc_state_t next_st;
    logic gap_timeout;
    logic wd_armed;
    logic pc_ok;
    logic [PC_W-1:0] pc_sel;

    // Valid select codes are 000 to 101
    function automatic logic sel_valid(input logic [2:0] s);
        return s <= 3'h5;
    endfunction

    function automatic logic [DATA_W-1:0] read_mux(input stlc_state_t s,
                                                   input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] r;
        r = '0;
        case (a)
            OFS_SERIAL_PORT_SETUP: r[7:0] = s.ser;
            OFS_TRACE_SYNC_POINT: r[PC_W-1:0] = s.sync_pt;
            OFS_TRACE_END_POINT: r[PC_W-1:0] = s.end_pt;
            OFS_TRACE_CONTROL: begin
                r[TC_EN_BIT] = s.en;
                r[TC_SEL_LSB +: 3] = s.sel;
                r[TC_LEN_LSB +: 8] = s.post_len;
            end
            OFS_WRITE_PROTECT_CONTROL: begin
                r[WP_DEV_BIT] = s.dev_lock;
                r[WP_RAM_LSB +: RAM_LOCKS] = s.ram_lock;
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    // Selected core counter, core/channel by code
    assign pc_ok = sel_valid(st.sel);
    assign pc_sel = pc_ok ? i_core_program_counter[st.sel] : '0;

    // Gap watchdog runs only in burst type A
    assign wd_armed = i_burst_active && !st.ser[SP_MODE_BIT];

    stlc_gap_watchdog #(
        .GAP_UNIT(GAP_UNIT),
        .CNT_W(21)
    ) u_gap_watchdog (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_armed(wd_armed),
        .i_cs_idle(st.cs_sync[1]),
        .i_setting(st.ser[SP_WD_LSB +: WD_W]),
        .o_timeout(gap_timeout)
    );

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.irq = 1'b0;
        next_st.tr_valid = 1'b0;
        next_st.cs_sync = {st.cs_sync[0], i_cs_n_pin};

        // Bad frame or gap overrun requests an interrupt
        if ((i_bad_frame || gap_timeout) && st.ser[SP_IRQ_BIT]) begin
            next_st.irq = 1'b1;
        end

        // Trace engine
        case (st.phase)
            TR_IDLE: begin
                next_st.dbg = 1'b0;
                if (st.en && pc_ok && pc_sel == st.sync_pt) begin
                    next_st.phase = TR_SYNC;
                    next_st.sync_sh = SYNC_CODE;
                    next_st.sync_left = 4'(SYNC_W);
                end
            end
            TR_SYNC: begin
                next_st.dbg = st.sync_sh[SYNC_W-1];
                next_st.sync_sh = {st.sync_sh[SYNC_W-2:0], 1'b0};
                next_st.sync_left = st.sync_left - 4'h1;
                if (st.sync_left == 4'h1) begin
                    next_st.phase = TR_TRACE;
                end
            end
            TR_TRACE: begin
                next_st.dbg = 1'b0;
                next_st.tr_valid = 1'b1;
                next_st.tr_pc = pc_sel;
                if (pc_sel == st.end_pt) begin
                    next_st.phase = TR_POST;
                    next_st.post_cnt = st.post_len;
                end
            end
            TR_POST: begin
                next_st.dbg = 1'b0;
                next_st.tr_valid = 1'b1;
                next_st.tr_pc = pc_sel;
                if (st.post_len != POST_FOREVER) begin
                    if (st.post_cnt == 8'h00) begin
                        next_st.tr_valid = 1'b0;
                        next_st.phase = TR_IDLE;
                        next_st.en = 1'b0;
                    end else begin
                        next_st.post_cnt = st.post_cnt - 8'h01;
                    end
                end
            end
            default: begin
                next_st.phase = TR_IDLE;
            end
        endcase

        // Register writes
        if (i_wr_en) begin
            case (i_addr)
                OFS_SERIAL_PORT_SETUP: begin
                    if (!st.dev_lock) begin
                        next_st.ser = i_wdata[7:0];
                    end
                end
                OFS_TRACE_SYNC_POINT: begin
                    next_st.sync_pt = i_wdata[PC_W-1:0];
                end
                OFS_TRACE_END_POINT: begin
                    next_st.end_pt = i_wdata[PC_W-1:0];
                end
                OFS_TRACE_CONTROL: begin
                    next_st.en = i_wdata[TC_EN_BIT];
                    next_st.sel = i_wdata[TC_SEL_LSB +: 3];
                    next_st.post_len = i_wdata[TC_LEN_LSB +: 8];
                    if (!i_wdata[TC_EN_BIT]) begin
                        next_st.phase = TR_IDLE;
                        next_st.dbg = 1'b0;
                        next_st.tr_valid = 1'b0;
                    end else if (!st.en) begin
                        next_st.phase = TR_IDLE;
                    end
                end
                OFS_WRITE_PROTECT_CONTROL: begin
                    next_st.dev_lock = st.dev_lock | i_wdata[WP_DEV_BIT];
                    for (int i = 0; i < RAM_LOCKS; i++) begin
                        if (!st.ram_lock[i]) begin
                            next_st.ram_lock[i] = i_wdata[WP_RAM_LSB + i];
                        end
                    end
                end
                OFS_UNLOCK_KEY: begin
                    if (i_wdata == UNLOCK_KEY) begin
                        next_st.dev_lock = 1'b0;
                        next_st.ram_lock = '0;
                    end
                end
                default: begin
                    next_st.ser = st.ser;
                end
            endcase
        end

        // Register reads
        if (i_rd_en) begin
            next_st.rdata = read_mux(st, i_addr);
            next_st.rvalid = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.ser <= RST_SERIAL_PORT_SETUP[7:0];
            st.sync_pt <= RST_TRACE_SYNC_POINT[PC_W-1:0];
            st.end_pt <= RST_TRACE_END_POINT[PC_W-1:0];
            st.en <= RST_TRACE_CONTROL[TC_EN_BIT];
            st.sel <= RST_TRACE_CONTROL[TC_SEL_LSB +: 3];
            st.post_len <= RST_TRACE_CONTROL[TC_LEN_LSB +: 8];
            st.dev_lock <= RST_WRITE_PROTECT_CONTROL[WP_DEV_BIT];
            st.ram_lock <= RST_WRITE_PROTECT_CONTROL[WP_RAM_LSB +: RAM_LOCKS];
            st.phase <= TR_IDLE;
            st.cs_sync <= 2'b11;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign o_rdata = st.rdata;
    assign o_rd_valid = st.rvalid;
    assign o_miso_fast_slew = st.ser[SP_SLEW_BIT];
    assign o_burst_mode_b = st.ser[SP_MODE_BIT];
    assign o_gap_timeout = gap_timeout;
    assign o_irq_req = st.irq;
    assign o_dbg = st.dbg;
    assign o_trace_valid = st.tr_valid;
    assign o_trace_pc = st.tr_pc;
    assign o_dev_lock = st.dev_lock;
    assign o_ram_tail_lock = st.ram_lock;
endmodule

// ### tb/stlc_asserts.sv
`timescale 1ns/100ps
module stlc_asserts
    import stlc_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register writes and bad frame input
    input wire logic i_wr_en,
    input wire logic [stlc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [stlc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_bad_frame,
    // Outputs watched
    input wire logic o_miso_fast_slew,
    input wire logic o_burst_mode_b,
    input wire logic o_gap_timeout,
    input wire logic o_irq_req,
    input wire logic o_dbg,
    input wire logic o_trace_valid,
    input wire logic o_dev_lock,
    input wire logic [stlc_pkg::RAM_LOCKS-1:0] o_ram_tail_lock
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic key_wr;
    assign key_wr = i_wr_en && i_addr == OFS_UNLOCK_KEY && i_wdata == UNLOCK_KEY;
    sequence s_key;
        key_wr;
    endsequence
    sequence s_locked_wr;
        o_dev_lock && i_wr_en && i_addr == OFS_SERIAL_PORT_SETUP;
    endsequence
    property p_setup;
        i_wr_en && i_addr == OFS_SERIAL_PORT_SETUP && !o_dev_lock |=>
            o_miso_fast_slew == $past(i_wdata[7]) && o_burst_mode_b == $past(i_wdata[6]);
    endproperty
    a_setup: assert property (p_setup) else $error("setup bits not taken");
    property p_irq;
        o_irq_req |-> $past(i_bad_frame) || $past(o_gap_timeout);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    property p_gap;
        o_gap_timeout |-> !$past(o_burst_mode_b);
    endproperty
    a_gap: assert property (p_gap) else $error("gap timeout in mode B");
    property p_stop;
        i_wr_en && i_addr == OFS_TRACE_CONTROL && !i_wdata[TC_EN_BIT] |=> !o_trace_valid && !o_dbg;
    endproperty
    a_stop: assert property (p_stop) else $error("trace not stopped");
    property p_lock;
        s_locked_wr |=> $stable(o_burst_mode_b) && $stable(o_miso_fast_slew);
    endproperty
    a_lock: assert property (p_lock) else $error("locked setup changed");
    property p_sticky;
        o_dev_lock && !key_wr |=> o_dev_lock;
    endproperty
    a_sticky: assert property (p_sticky) else $error("lock cleared without key");
    property p_key;
        s_key |=> !o_dev_lock && o_ram_tail_lock == 3'h0;
    endproperty
    a_key: assert property (p_key) else $error("key did not unlock");
    property p_ram;
        !key_wr |=> (o_ram_tail_lock & $past(o_ram_tail_lock)) == $past(o_ram_tail_lock);
    endproperty
    a_ram: assert property (p_ram) else $error("tail lock dropped");
endmodule
bind stlc_config_bank stlc_asserts u_chk (.i_ref_clk, .i_rst, .i_wr_en, .i_addr, .i_wdata,
    .i_bad_frame, .o_miso_fast_slew, .o_burst_mode_b, .o_gap_timeout, .o_irq_req, .o_dbg,
    .o_trace_valid, .o_dev_lock, .o_ram_tail_lock);

// ### tb/stlc_mcu_model.sv
`timescale 1ns/100ps
module stlc_mcu_model
    import stlc_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Register requests
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [stlc_pkg::ADDR_W-1:0] o_addr,
    output logic [stlc_pkg::DATA_W-1:0] o_wdata
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 10'h000;
        o_wdata = 16'h0000;
    end
    // Whole word in one strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_ref_clk);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_ref_clk);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        o_addr <= ~a;
    endtask
endmodule

// ### tb/stlc_config_bank_tb.sv
`timescale 1ns/100ps
module stlc_config_bank_tb;
    import stlc_pkg::*;
    localparam logic [7:0] CODE = 8'ha5;
    localparam int GAP_SIM = 4;
    logic i_ref_clk, i_rst, i_wr_en, i_rd_en, i_bad_frame, i_burst_active, i_cs_n_pin;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, sp;
    logic o_rd_valid, o_miso_fast_slew, o_burst_mode_b, o_gap_timeout, o_irq_req;
    logic [NUM_CORES-1:0][PC_W-1:0] i_core_program_counter;
    logic o_dbg, o_trace_valid, o_dev_lock;
    logic [PC_W-1:0] o_trace_pc;
    logic [RAM_LOCKS-1:0] o_ram_tail_lock;
    logic [15:0] q[$];
    int failures, checks_done, cyc, n, sel;
    stlc_config_bank #(.GAP_UNIT(GAP_SIM), .SYNC_CODE(CODE)) dut (.i_ref_clk, .i_rst, .i_wr_en,
        .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rd_valid, .i_bad_frame, .i_burst_active,
        .i_cs_n_pin, .o_miso_fast_slew, .o_burst_mode_b, .o_gap_timeout, .o_irq_req,
        .i_core_program_counter, .o_dbg, .o_trace_valid, .o_trace_pc, .o_dev_lock,
        .o_ram_tail_lock);
    stlc_mcu_model u_mcu (.i_ref_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
        .o_wdata(i_wdata));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        q.push_back(e);
        u_mcu.rd(a);
    endtask
    task automatic conclude;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic trace(input logic [7:0] len);
        u_mcu.wr(OFS_TRACE_CONTROL, {5'h10, 3'(sel), len});
        @(posedge i_ref_clk);
        i_core_program_counter[sel] <= 10'h010;
        @(posedge i_ref_clk);
        i_core_program_counter[sel] <= 10'h3ff;
        @(posedge i_ref_clk);
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_ref_clk);
            chk(16'(o_dbg), 16'(CODE[i]));
        end
        repeat (2) @(posedge i_ref_clk);
        i_core_program_counter[sel] <= 10'h020;
        @(posedge i_ref_clk);
        i_core_program_counter[sel] <= 10'h3ff;
        @(posedge i_ref_clk);
        chk(16'(o_trace_pc), 16'h0020);
        n = int'(o_trace_valid);
        repeat (int'(len) + 3) begin
            @(posedge i_ref_clk);
            n += int'(o_trace_valid);
        end
        chk(16'(n), len == POST_FOREVER ? 16'd259 : 16'(len) + 16'd1);
        if (len == POST_FOREVER) begin
            u_mcu.wr(OFS_TRACE_CONTROL, {5'h00, 3'(sel), len});
            @(posedge i_ref_clk);
            chk(16'(o_trace_valid), 16'h0000);
        end
        rd(OFS_TRACE_CONTROL, {5'h00, 3'(sel), len});
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc++;
        if (o_rd_valid === 1'b1) chk(o_rdata, q.pop_front());
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        i_rst = 1'b1;
        i_bad_frame = 1'b0;
        i_burst_active = 1'b0;
        i_cs_n_pin = 1'b1;
        i_core_program_counter = '1;
        void'($urandom(49));
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(OFS_SERIAL_PORT_SETUP + 10'(i), i == 0 ? RST_SERIAL_PORT_SETUP : 16'h0000);
        end
        $display("reset values done");
        for (int i = 0; i < 6; i++) begin
            sp = 16'($urandom) & 16'h00ff;
            u_mcu.wr(OFS_SERIAL_PORT_SETUP, sp);
            rd(OFS_SERIAL_PORT_SETUP, sp);
            chk(16'({o_miso_fast_slew, o_burst_mode_b}), 16'(sp[7:6]));
        end
        $display("setup done");
        for (int k = 0; k < 2; k++) begin
            u_mcu.wr(OFS_SERIAL_PORT_SETUP, k == 0 ? 16'h0021 : 16'h0001);
            @(posedge i_ref_clk);
            i_bad_frame <= 1'b1;
            @(posedge i_ref_clk);
            i_bad_frame <= 1'b0;
            n = 0;
            repeat (3) begin
                @(posedge i_ref_clk);
                n += int'(o_irq_req);
            end
            chk(16'(n), 16'(k == 0));
        end
        u_mcu.wr(OFS_SERIAL_PORT_SETUP, 16'h0021);
        @(posedge i_ref_clk);
        i_burst_active <= 1'b1;
        i_cs_n_pin <= 1'b0;
        n = 0;
        repeat (4) begin
            @(posedge i_ref_clk);
            n += int'(o_gap_timeout);
        end
        chk(16'(n), 16'h0000);
        i_cs_n_pin <= 1'b1;
        n = 0;
        while (o_gap_timeout !== 1'b1 && n < 40) begin
            @(posedge i_ref_clk);
            n++;
        end
        // Gap of (1 + 1) units, plus two sync stages and the sampling edge
        chk(16'(n), 16'((1 + 1) * GAP_SIM + 3));
        i_burst_active <= 1'b0;
        u_mcu.wr(OFS_SERIAL_PORT_SETUP, 16'h0061);
        i_burst_active <= 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge i_ref_clk);
            n += int'(o_gap_timeout);
        end
        chk(16'(n), 16'h0000);
        i_burst_active <= 1'b0;
        $display("watchdog done");
        sel = $urandom_range(5, 0);
        u_mcu.wr(OFS_TRACE_SYNC_POINT, 16'h0010);
        u_mcu.wr(OFS_TRACE_END_POINT, 16'h0020);
        trace(8'h03);
        trace(POST_FOREVER);
        $display("trace done");
        u_mcu.wr(OFS_WRITE_PROTECT_CONTROL, 16'h000f);
        u_mcu.wr(OFS_SERIAL_PORT_SETUP, 16'h0080);
        rd(OFS_SERIAL_PORT_SETUP, 16'h0061);
        u_mcu.wr(OFS_TRACE_SYNC_POINT, 16'h0155);
        rd(OFS_TRACE_SYNC_POINT, 16'h0155);
        u_mcu.wr(OFS_WRITE_PROTECT_CONTROL, 16'h0000);
        rd(OFS_WRITE_PROTECT_CONTROL, 16'h000f);
        u_mcu.wr(OFS_UNLOCK_KEY, UNLOCK_KEY);
        rd(OFS_WRITE_PROTECT_CONTROL, 16'h0000);
        u_mcu.wr(OFS_WRITE_PROTECT_CONTROL, 16'h0002);
        u_mcu.wr(OFS_WRITE_PROTECT_CONTROL, 16'h0004);
        rd(OFS_WRITE_PROTECT_CONTROL, 16'h0006);
        repeat (4) @(posedge i_ref_clk);
        $display("lock done");
        conclude();
    end
endmodule
